/* rtl/sefe_pkg.sv */
// What this block does
// [R01] sample SDA on SCL rise, drive after fall
// [R02] controller keeps SCL at most 400 kHz; the bench controller runs it at up to 2.5 MHz
// [R03] SDA driven low only, else released
// [R04] data changes only while SCL low
// [R05] answer only when select code matches straps
// [R06] unconnected select pins read as low
// [R07] write protect: ack addresses, refuse data bytes
// [R08] write protect low: every location writable
// [R09] reads work whatever write protect says
// [R10] SDA fall with SCL high is start
// [R11] SDA rise with SCL high is stop
// [R12] stop after write data starts programming
// [R13] eight bits, then ninth clock acknowledge
// [R14] write: acknowledge every received word low
// [R15] read: ack address word, release after bytes
// [R16] controller ack low: send next byte
// [R17] no-ack then stop ends read, standby
// [R18] otherwise keep SDA released, send nothing
// [R19] address word: type, select high first, direction
// [R20] direction zero writes, one reads
// [R21] mismatch: no acknowledge, back to standby
// [R22] programming ends within write cycle time
// [R23] any start restarts address word reception; the code ignores starts while programming
package sefe_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_HZ          = 20_000_000;
  localparam int WC_TIME_MS      = 5;
  localparam int MS_PER_S        = 1000;
  localparam int PROG_CYCLES_DEF = WC_TIME_MS * (CLK_HZ / MS_PER_S);
  localparam int PROG_W          = 17;

  ////////////////////////////////////////////////////////////////////////////
  // word layout and counts
  localparam int               SYNC_W       = 6;
  localparam int               CNT_W        = 4;
  localparam logic [CNT_W-1:0] BITS_PER_WORD = 4'h8;
  localparam int               TYPE_MSB     = 7;
  localparam int               TYPE_LSB     = 4;
  localparam int               SEL_MSB      = 3;
  localparam int               SEL_LSB      = 1;
  localparam int               DIR_BIT      = 0;
  localparam int               MSB_BIT      = 7;
  localparam logic [1:0]       ADDR_BYTES   = 2'h2;
  localparam int               MEM_ADDR_W   = 15;
  localparam int               HI_ADDR_W    = 7;

  ////////////////////////////////////////////////////////////////////////////
  // transfer states
  typedef enum logic [2:0] {
    SEFE_IDLE,
    SEFE_DEV_WORD,
    SEFE_WR_WORD,
    SEFE_RD_WORD,
    SEFE_RD_ACK,
    SEFE_WAIT_STOP,
    SEFE_PROG
  } sefe_state_t;

endpackage

/* rtl/sefe_pin_sync.sv */
// two-stage synchroniser for asynchronous pins
module sefe_pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         rst_b_i,
  // pins in, synchronised out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // first stage read only by second stage
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;

endmodule

/* rtl/sefe_top.sv */
// two-wire bus front end of a serial memory, target side
//
// Implementation choices: strobed register access and the placing of the registers.
module sefe_top #(
  parameter logic [3:0] TYPE_CODE   = 4'h5,                     // arbitrary value
  parameter int         PROG_CYCLES = sefe_pkg::PROG_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                            clock_i,
  input  wire logic                            rst_b_i,
  // two-wire bus
  input  wire logic                            scl_i,
  input  wire logic                            sda_i,
  output logic                                 sda_o,
  output logic                                 sda_oe_o,
  // straps and protection
  input  wire logic                            select_pin_0_i,
  input  wire logic                            select_pin_1_i,
  input  wire logic                            select_pin_2_i,
  input  wire logic                            wp_i,
  // memory side
  input  wire logic [7:0]                      rd_data_i,
  output logic                                 rd_strobe_o,
  output logic [sefe_pkg::MEM_ADDR_W-1:0]      mem_addr_o,
  output logic                                 mem_addr_valid_o,
  output logic [7:0]                           wr_data_o,
  output logic                                 wr_strobe_o,
  output logic                                 prog_start_o,
  output logic                                 prog_busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edge detection

  logic [sefe_pkg::SYNC_W-1:0] sync_w;
  logic                        scl_s;
  logic                        sda_s;
  logic                        wp_s;
  logic [2:0]                  sel_s;
  logic                        scl_q_reg;
  logic                        sda_q_reg;

  sefe_pin_sync #(
    .W (sefe_pkg::SYNC_W)
  ) u_sync (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .d_i     ({scl_i, sda_i, wp_i, select_pin_2_i, select_pin_1_i, select_pin_0_i}),
    .q_o     (sync_w)
  );

  // unpack synchronised pins; straps ordered highest first
  assign scl_s = sync_w[5];
  assign sda_s = sync_w[4];
  assign wp_s  = sync_w[3];
  assign sel_s = sync_w[2:0];  // R06

  // previous synchronised levels
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      scl_q_reg <= 1'b0;
      sda_q_reg <= 1'b0;
    end else begin
      scl_q_reg <= scl_s;
      sda_q_reg <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // bus events
  assign scl_rise  = scl_s & ~scl_q_reg;                          // R01
  assign scl_fall  = ~scl_s & scl_q_reg;                          // R01
  assign start_det = scl_s & scl_q_reg & sda_q_reg & ~sda_s;      // R10
  assign stop_det  = scl_s & scl_q_reg & ~sda_q_reg & sda_s;      // R11

  ////////////////////////////////////////////////////////////////////////////
  // state and datapath registers

  sefe_pkg::sefe_state_t             state_reg;
  logic [sefe_pkg::CNT_W-1:0]        bit_cnt_reg;
  logic                              ack_phase_reg;
  logic [7:0]                        rx_reg;
  logic [7:0]                        tx_reg;
  logic                              dir_reg;
  logic [1:0]                        wr_idx_reg;
  logic                              data_seen_reg;
  logic                              ack_ok_reg;
  logic [sefe_pkg::PROG_W-1:0]       timer_reg;
  logic                              sda_oe_reg;
  logic                              sda_o_reg;
  logic                              rd_strobe_reg;
  logic                              wr_strobe_reg;
  logic                              prog_start_reg;
  logic                              addr_valid_reg;
  logic [sefe_pkg::HI_ADDR_W-1:0]    addr_hi_reg;
  logic [sefe_pkg::MEM_ADDR_W-1:0]   mem_addr_reg;
  logic [7:0]                        wr_data_reg;

  ////////////////////////////////////////////////////////////////////////////
  // decoding

  // local copy so the timer casts stay short
  localparam int PROG_W = sefe_pkg::PROG_W;

  logic word_done;
  logic type_match;
  logic sel_match;
  logic addr_match;
  logic in_addr_bytes;
  logic bit_room;
  logic timer_done;

  assign word_done     = (bit_cnt_reg == sefe_pkg::BITS_PER_WORD);                 // R13
  assign bit_room      = (bit_cnt_reg <  sefe_pkg::BITS_PER_WORD);
  assign type_match    = (rx_reg[sefe_pkg::TYPE_MSB:sefe_pkg::TYPE_LSB] == TYPE_CODE);   // R19
  assign sel_match     = (rx_reg[sefe_pkg::SEL_MSB:sefe_pkg::SEL_LSB] == sel_s);          // R05
  assign addr_match    = type_match & sel_match;                                   // R21
  assign in_addr_bytes = (wr_idx_reg < sefe_pkg::ADDR_BYTES);
  assign timer_done    = (timer_reg == PROG_W'(1));

  ////////////////////////////////////////////////////////////////////////////
  // next values and shared decodes

  logic                            in_prog;
  logic                            in_dev_word;
  logic                            first_addr_byte;
  logic                            rd_launch;
  logic                            prog_launch;
  logic                            bit_in;
  logic                            word_end;
  logic                            ack_end;
  logic [7:0]                      rx_next;
  logic [7:0]                      tx_next;
  logic [PROG_W-1:0]               timer_next;
  logic [1:0]                      wr_idx_next;
  logic [sefe_pkg::MEM_ADDR_W-1:0] mem_addr_next;
  logic                            prog_busy_next;

  // state decodes used by the sequencer and the busy flag
  assign in_prog         = (state_reg == sefe_pkg::SEFE_PROG);
  assign in_dev_word     = (state_reg == sefe_pkg::SEFE_DEV_WORD);
  assign first_addr_byte = (wr_idx_reg == 2'h0);
  assign rd_launch       = in_dev_word & dir_reg;  // R20
  assign prog_launch     = (state_reg == sefe_pkg::SEFE_WR_WORD) & data_seen_reg;  // R12

  // bus clock events inside a word
  assign bit_in   = scl_rise & bit_room;                    // R01
  assign word_end = scl_fall & word_done & ~ack_phase_reg;  // R13
  assign ack_end  = scl_fall & ack_phase_reg;               // R13

  // shifters, most significant bit first
  assign rx_next = {rx_reg[6:0], sda_s};
  assign tx_next = {tx_reg[6:0], 1'b0};

  // counters and address assembly
  assign timer_next    = timer_reg - PROG_W'(1);
  assign wr_idx_next   = wr_idx_reg + 2'h1;
  assign mem_addr_next = {addr_hi_reg, rx_reg};

  // busy from the launch edge until the timer expires
  assign prog_busy_next = (in_prog & ~timer_done) | prog_start_reg;  // R12 R22

  // next bit counter value
  function automatic logic [sefe_pkg::CNT_W-1:0] bump(input logic [sefe_pkg::CNT_W-1:0] c);
    bump = c + sefe_pkg::CNT_W'(1);
  endfunction

  // open-drain enable for one data bit: pull low for a zero
  function automatic logic drive_low(input logic b);
    drive_low = ~b;  // R03
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // transfer sequencer

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state_reg      <= sefe_pkg::SEFE_IDLE;
      bit_cnt_reg    <= '0;
      ack_phase_reg  <= 1'b0;
      rx_reg         <= 8'h00;
      tx_reg         <= 8'h00;
      dir_reg        <= 1'b0;
      wr_idx_reg     <= 2'h0;
      data_seen_reg  <= 1'b0;
      ack_ok_reg     <= 1'b0;
      timer_reg      <= '0;
      sda_oe_reg     <= 1'b0;
      sda_o_reg      <= 1'b0;
      rd_strobe_reg  <= 1'b0;
      wr_strobe_reg  <= 1'b0;
      prog_start_reg <= 1'b0;
      addr_valid_reg <= 1'b0;
      addr_hi_reg    <= '0;
      mem_addr_reg   <= '0;
      wr_data_reg    <= 8'h00;
    end else begin
      sda_o_reg      <= 1'b0;                              // R03
      rd_strobe_reg  <= 1'b0;
      wr_strobe_reg  <= 1'b0;
      prog_start_reg <= 1'b0;
      addr_valid_reg <= 1'b0;
      if (in_prog) begin
        // bus ignored until programming completes
        sda_oe_reg <= 1'b0;
        if (timer_done) begin
          state_reg <= sefe_pkg::SEFE_IDLE;                // R12 R22
        end
        timer_reg <= timer_next;
      end else if (start_det) begin
        state_reg     <= sefe_pkg::SEFE_DEV_WORD;          // R23 R10
        bit_cnt_reg   <= '0;
        ack_phase_reg <= 1'b0;
        ack_ok_reg    <= 1'b0;
        sda_oe_reg    <= 1'b0;
      end else if (stop_det) begin
        sda_oe_reg    <= 1'b0;
        ack_phase_reg <= 1'b0;
        if (prog_launch) begin
          state_reg      <= sefe_pkg::SEFE_PROG;           // R12
          timer_reg      <= PROG_W'(PROG_CYCLES);          // R22
          prog_start_reg <= 1'b1;
        end else begin
          state_reg <= sefe_pkg::SEFE_IDLE;                // R11 R17
        end
      end else begin
        case (state_reg)
          sefe_pkg::SEFE_DEV_WORD,
          sefe_pkg::SEFE_WR_WORD: begin
            if (bit_in) begin
              rx_reg      <= rx_next;                      // R01 R13
              bit_cnt_reg <= bump(bit_cnt_reg);
            end else if (word_end) begin
              ack_phase_reg <= 1'b1;
              if (in_dev_word) begin
                if (addr_match) begin
                  sda_oe_reg <= 1'b1;                      // R21 R15
                  dir_reg    <= rx_reg[sefe_pkg::DIR_BIT]; // R20
                end else begin
                  state_reg <= sefe_pkg::SEFE_IDLE;        // R21
                end
              end else if (in_addr_bytes) begin
                sda_oe_reg <= 1'b1;                        // R07 R14
                wr_idx_reg <= wr_idx_next;
                if (first_addr_byte) begin
                  addr_hi_reg <= rx_reg[sefe_pkg::HI_ADDR_W-1:0];
                end else begin
                  mem_addr_reg   <= mem_addr_next;
                  addr_valid_reg <= 1'b1;
                end
              end else if (wp_s) begin
                sda_oe_reg <= 1'b0;                        // R07
              end else begin
                sda_oe_reg    <= 1'b1;                     // R14 R08
                wr_data_reg   <= rx_reg;
                wr_strobe_reg <= 1'b1;
                data_seen_reg <= 1'b1;
              end
            end else if (ack_end) begin
              // end of ninth clock: release, or drive first read bit, then next word
              ack_phase_reg <= 1'b0;
              bit_cnt_reg   <= '0;
              if (rd_launch) begin
                state_reg  <= sefe_pkg::SEFE_RD_WORD;      // R20 R09
                tx_reg     <= rd_data_i;
                sda_oe_reg <= drive_low(rd_data_i[sefe_pkg::MSB_BIT]);  // R01 R04
              end else begin
                if (in_dev_word) begin
                  wr_idx_reg    <= 2'h0;
                  data_seen_reg <= 1'b0;
                end
                state_reg  <= sefe_pkg::SEFE_WR_WORD;      // R20
                sda_oe_reg <= 1'b0;                        // R13
              end
            end
          end
          sefe_pkg::SEFE_RD_WORD: begin
            if (bit_in) begin
              bit_cnt_reg <= bump(bit_cnt_reg);
            end else if (scl_fall && word_done) begin
              sda_oe_reg <= 1'b0;                          // R15 R13
              state_reg  <= sefe_pkg::SEFE_RD_ACK;
            end else if (scl_fall) begin
              tx_reg     <= tx_next;
              sda_oe_reg <= drive_low(tx_next[sefe_pkg::MSB_BIT]);  // R01 R04
            end
          end
          sefe_pkg::SEFE_RD_ACK: begin
            if (scl_rise) begin
              if (!sda_s) begin
                ack_ok_reg    <= 1'b1;                     // R16
                rd_strobe_reg <= 1'b1;
              end else begin
                state_reg <= sefe_pkg::SEFE_WAIT_STOP;     // R17 R18
              end
            end else if (scl_fall && ack_ok_reg) begin
              ack_ok_reg  <= 1'b0;
              bit_cnt_reg <= '0;
              tx_reg      <= rd_data_i;                    // R16
              sda_oe_reg  <= drive_low(rd_data_i[sefe_pkg::MSB_BIT]);
              state_reg   <= sefe_pkg::SEFE_RD_WORD;
            end
          end
          sefe_pkg::SEFE_WAIT_STOP: begin
            sda_oe_reg <= 1'b0;                            // R18
          end
          default: begin
            sda_oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // busy flag kept as its own flop

  logic prog_busy_reg;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      prog_busy_reg <= 1'b0;
    end else begin
      prog_busy_reg <= prog_busy_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops

  assign sda_o            = sda_o_reg;
  assign sda_oe_o         = sda_oe_reg;
  assign rd_strobe_o      = rd_strobe_reg;
  assign mem_addr_o       = mem_addr_reg;
  assign mem_addr_valid_o = addr_valid_reg;
  assign wr_data_o        = wr_data_reg;
  assign wr_strobe_o      = wr_strobe_reg;
  assign prog_start_o     = prog_start_reg;
  assign prog_busy_o      = prog_busy_reg;

endmodule

/* test/sefe_props.sv */
// protocol checker on the pins of the bus front end
module sefe_props #(
  parameter int PROG_CYCLES = 40
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic wp_i,
  // memory side strobes
  input wire logic rd_strobe_o,
  input wire logic mem_addr_valid_o,
  input wire logic wr_strobe_o,
  input wire logic prog_start_o,
  input wire logic prog_busy_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [16:0] busy_cnt;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  // cycles spent with the programming timer running
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || !prog_busy_o) busy_cnt <= 17'h0_0000;
    else busy_cnt <= busy_cnt + 17'h0_0001;
  end

  ////////////////////////////////////////
  // stop on the pins: data rises while clock high
  sequence s_stop_pin;
    (scl_i && !sda_i) ##1 (scl_i && sda_i);
  endsequence
  // programming launched, timer then runs
  sequence s_launch;
    prog_start_o ##1 prog_busy_o [*8];
  endsequence

  // pin drive and timing
  a_ack_on_fall: assert property ($rose(sda_oe_o) |-> $past(scl_i, 4) && !$past(scl_i, 3))
    else $error("data drive started away from a clock fall");
  a_drive_low_only: assert property (sda_oe_o |-> !sda_o)
    else $error("data pin driven high");
  a_idle_after_stop: assert property (s_stop_pin |-> ##1 !sda_oe_o [*8])
    else $error("data pin driven after stop");
  // programming cycle
  a_prog_launch: assert property (prog_start_o |-> s_launch)
    else $error("timer not running after launch");
  a_prog_on_stop: assert property (prog_start_o |-> !$past(sda_i, 4) && $past(sda_i, 3) && $past(scl_i, 3))
    else $error("programming launched without stop");
  a_prog_bound: assert property (busy_cnt <= PROG_CYCLES)
    else $error("programming cycle too long");
  a_quiet_busy: assert property (prog_busy_o |-> !sda_oe_o)
    else $error("bus answered while programming");
  // acknowledge and strobes
  a_wr_unprotected: assert property (wr_strobe_o |-> !$past(wp_i, 3))
    else $error("write accepted while protected");
  a_wr_acked: assert property (wr_strobe_o |-> ##[0:1] sda_oe_o)
    else $error("data byte not acknowledged");
  a_addr_acked: assert property (mem_addr_valid_o |-> ##[0:1] sda_oe_o)
    else $error("address byte not acknowledged");
  a_rd_on_ack: assert property (rd_strobe_o |-> !sda_i && !sda_oe_o)
    else $error("read advanced without controller ack");
endmodule

bind sefe_top sefe_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .wp_i(wp_i), .rd_strobe_o(rd_strobe_o), .mem_addr_valid_o(mem_addr_valid_o),
  .wr_strobe_o(wr_strobe_o), .prog_start_o(prog_start_o), .prog_busy_o(prog_busy_o)
);

/* test/sefe_ctrl_model.sv */
// two-wire bus controller driving clock and open-drain data
module sefe_ctrl_model (
  // clock
  input  wire logic clock_i,
  // wire view
  input  wire logic dev_oe_i,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic drv_low = 1'b0;
  // clocks from data change to clock rise, part of the low phase; with the high phase it sets the bus clock period
  int   hold    = 2;

  initial scl_o = 1'b1;

  // open-drain data line with pull-up
  assign sda_o = ~(drv_low | dev_oe_i);

  ////////////////////////////////////////
  // wait whole clock cycles
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // one bit: change data while clock low, sample while high
  task automatic clk_bit(input logic b, output logic r);
    drv_low <= ~b;
    wait_n(hold);
    scl_o <= 1'b1;
    wait_n(2);
    r = sda_o;
    wait_n(2);
    scl_o <= 1'b0;
    wait_n(2);
  endtask

  // start: data falls while clock high
  task automatic start();
    drv_low <= 1'b0;
    wait_n(hold);
    scl_o <= 1'b1;
    wait_n(4);
    drv_low <= 1'b1;
    wait_n(4);
    scl_o <= 1'b0;
    wait_n(2);
  endtask

  // stop: data rises while clock high
  task automatic stop();
    drv_low <= 1'b1;
    wait_n(hold);
    scl_o <= 1'b1;
    wait_n(4);
    drv_low <= 1'b0;
    wait_n(4);
  endtask

  // eight bits out, msb first, then sample acknowledge
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, ack);
  endtask

  // eight bits in, then answer with ack level
  task automatic get_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(ack, r);
  endtask
endmodule

/* test/sefe_top_bench.sv */
// self-checking bench for the bus front end
module sefe_top_bench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [3:0] TYPE_C = 4'h5; // arbitrary value
  localparam int         PROG   = 400;
  localparam logic [2:0] SEL    = 3'h5;

  logic        clock_i   = 1'b0;
  logic        rst_b_i   = 1'b0;
  logic        wp_i      = 1'b0;
  logic [2:0]  sel       = SEL;
  logic [7:0]  rd_data_i = 8'h96;
  logic        scl, sda, sda_o, sda_oe_o, rd_strobe_o, mem_addr_valid_o, wr_strobe_o, prog_start_o, prog_busy_o;
  logic [14:0] mem_addr_o;
  logic [7:0]  wr_data_o;
  int          fail_count = 0;
  int          checked    = 0;
  int          n_wr       = 0;
  int          n_av       = 0;
  int          n_prog     = 0;

  // clock
  always #25 clock_i = ~clock_i;

  // pulse counters and memory-side data source
  always @(posedge clock_i) begin
    n_wr   += int'(wr_strobe_o === 1'b1);
    n_av   += int'(mem_addr_valid_o === 1'b1);
    n_prog += int'(prog_start_o === 1'b1);
    if (rd_strobe_o === 1'b1) rd_data_i <= rd_data_i + 8'h11;
  end

  sefe_top #(.TYPE_CODE(TYPE_C), .PROG_CYCLES(PROG)) u_dut (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .select_pin_0_i(sel[0]), .select_pin_1_i(sel[1]), .select_pin_2_i(sel[2]), .wp_i(wp_i),
    .rd_data_i(rd_data_i), .rd_strobe_o(rd_strobe_o), .mem_addr_o(mem_addr_o),
    .mem_addr_valid_o(mem_addr_valid_o), .wr_data_o(wr_data_o), .wr_strobe_o(wr_strobe_o),
    .prog_start_o(prog_start_o), .prog_busy_o(prog_busy_o)
  );
  sefe_ctrl_model u_ctrl (.clock_i(clock_i), .dev_oe_i(sda_oe_o), .scl_o(scl), .sda_o(sda));

  ////////////////////////////////////////
  // verdict and end of run
  task automatic stop_test();
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // compare one value
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // device word from select code and direction
  function automatic logic [7:0] dev(input logic [2:0] s, input logic rd);
    return {TYPE_C, s, rd};
  endfunction

  // start then device word
  task automatic open_dev(input logic [7:0] w, output logic ack);
    u_ctrl.start();
    u_ctrl.put_byte(w, ack);
  endtask

  ////////////////////////////////////////
  // byte write, refused start while busy, timer end
  task automatic t_write();
    logic a;
    wp_i <= 1'b0;
    open_dev(dev(SEL, 1'b0), a);
    check("write dev ack", 16'h0000, 16'(a));
    u_ctrl.put_byte(8'h12, a);
    check("hi ack", 16'h0000, 16'(a));
    u_ctrl.put_byte(8'h34, a);
    check("lo ack", 16'h0000, 16'(a));
    check("mem addr", 16'h1234, 16'(mem_addr_o));
    check("addr valid", 16'h0001, 16'(n_av));
    u_ctrl.put_byte(8'hc3, a);
    check("data ack", 16'h0000, 16'(a));
    check("wr data", 16'h00c3, 16'(wr_data_o));
    check("wr count", 16'h0001, 16'(n_wr));
    u_ctrl.stop();
    open_dev(dev(SEL, 1'b0), a);
    check("busy ack", 16'h0001, 16'(a));
    check("busy", 16'h0001, 16'(prog_busy_o));
    u_ctrl.stop();
    repeat (PROG) @(posedge clock_i);
    check("prog count", 16'h0001, 16'(n_prog));
    check("busy end", 16'h0000, 16'(prog_busy_o));
  endtask

  // protected write: addresses acked, data refused
  task automatic t_protect();
    logic a;
    wp_i <= 1'b1;
    open_dev(dev(SEL, 1'b0), a);
    check("wp dev ack", 16'h0000, 16'(a));
    u_ctrl.put_byte(8'h01, a);
    check("wp hi ack", 16'h0000, 16'(a));
    u_ctrl.put_byte(8'h02, a);
    check("wp lo ack", 16'h0000, 16'(a));
    u_ctrl.put_byte(8'h5a, a);
    check("wp data nack", 16'h0001, 16'(a));
    u_ctrl.stop();
    repeat (20) @(posedge clock_i);
    check("wp wr count", 16'h0001, 16'(n_wr));
    check("wp prog count", 16'h0001, 16'(n_prog));
  endtask

  // mismatching words, restart mid-word, open straps
  task automatic t_select();
    logic       a;
    logic       r;
    logic [7:0] bad [3];
    bad = '{{TYPE_C, SEL ^ 3'h1, 1'b0}, {TYPE_C, SEL ^ 3'h4, 1'b0}, {~TYPE_C, SEL, 1'b0}};
    foreach (bad[i]) begin
      open_dev(bad[i], a);
      check("mismatch ack", 16'h0001, 16'(a));
    end
    u_ctrl.start();
    repeat (3) u_ctrl.clk_bit(1'b0, r);
    open_dev(dev(SEL, 1'b0), a);
    check("restart ack", 16'h0000, 16'(a));
    u_ctrl.stop();
    sel <= 3'h0;
    open_dev(dev(3'h0, 1'b0), a);
    check("open strap ack", 16'h0000, 16'(a));
    u_ctrl.stop();
    sel <= SEL;
  endtask

  // sequential read under protection, slow controller
  task automatic t_read();
    logic       a;
    logic [7:0] d;
    u_ctrl.hold = 6;
    open_dev(dev(SEL, 1'b1), a);
    check("read dev ack", 16'h0000, 16'(a));
    u_ctrl.get_byte(1'b0, d);
    check("read byte 0", 16'h0096, 16'(d));
    u_ctrl.get_byte(1'b0, d);
    check("read byte 1", 16'h00a7, 16'(d));
    u_ctrl.get_byte(1'b1, d);
    check("read byte 2", 16'h00b8, 16'(d));
    u_ctrl.get_byte(1'b1, d);
    check("after nack", 16'h00ff, 16'(d));
    u_ctrl.stop();
    u_ctrl.hold = 2;
    open_dev(dev(SEL, 1'b1), a);
    u_ctrl.get_byte(1'b1, d);
    check("read again", 16'h00b8, 16'(d));
    u_ctrl.stop();
  endtask

  ////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    t_write();
    t_protect();
    t_select();
    t_read();
    stop_test();
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    stop_test();
  end
endmodule
